// *** logic/sws_ctrl.sv ***
`timescale 1ns/100ps
// Contract
// - Write when global low or byte lane active
// - All inactive means read cycle
// - Output enable used combinationally, never sampled
// - Read drives data only when enable low
// - Processor strobe starts a read only when selected, never a write
// - Write data after processor strobe or controller
// - Byte write touches only selected lanes
// - Byte enable high or no lanes reads
// - Global write or all selects writes all
// - Stay floating after write until new read
// - Data floats on leaving sleep
// - Processor strobe ignored when first select high
// - Controller write finishes in one cycle
// - Data floats whenever write cycle detected
module sws_ctrl
(
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic proc_addr_strobe_n,
   input wire logic ctrl_addr_strobe_n,
   input wire logic burst_advance_n,
   input wire logic chip_sel_first_n,
   input wire logic chip_sel_second,
   input wire logic chip_sel_third_n,
   input wire logic global_write_n,
   input wire logic byte_write_enable_n,
   input wire logic [3:0] byte_lane_select_n,
   input wire logic sleep_request,
   input wire logic output_enable_n,
   output logic [3:0] lane_write,
   output logic write_strobe,
   output logic [3:0] data_oe,
   output logic read_active,
   output logic sleeping
);
   sws_pkg::sws_state_e state;
   sws_pkg::sws_state_e next_state;
   logic [1:0] sleep_cnt;
   logic [1:0] next_sleep_cnt;
   logic [3:0] lanes;
   logic is_write;
   logic selected;
   logic proc_start;
   logic ctrl_start;
   logic cont;
   logic [3:0] next_lane_write;
   logic next_write_strobe;
   logic drive_q;
   logic next_drive_q;

   sws_lane_decode u_dec
   (
      .global_write_n(global_write_n),
      .byte_write_enable_n(byte_write_enable_n),
      .byte_lane_select_n(byte_lane_select_n),
      .lanes(lanes),
      .is_write(is_write)
   );

   always_comb
   begin
      selected = !chip_sel_first_n && chip_sel_second && !chip_sel_third_n;
      proc_start = !proc_addr_strobe_n && !chip_sel_first_n;
      // An ignored processor strobe must not block deselect or burst continuation
      ctrl_start = !ctrl_addr_strobe_n && !proc_start;
      cont = !proc_start && ctrl_addr_strobe_n && state != sws_pkg::SWS_IDLE;
      next_state = state;
      next_sleep_cnt = sleep_cnt;
      next_lane_write = sws_pkg::LANES_NONE;
      next_write_strobe = 1'b0;
      next_drive_q = 1'b0;
      if (sleep_request)
      begin
         // Pending access is abandoned on entry
         next_state = sws_pkg::SWS_SLEEP;
         next_sleep_cnt = sws_pkg::SLEEP_CNT_RST;
      end
      else if (state == sws_pkg::SWS_SLEEP)
      begin
         // Recovery takes two cycles; bus stays floating meanwhile
         if (sleep_cnt == 2'(sws_pkg::SLEEP_CYCLES - 1))
            next_state = sws_pkg::SWS_IDLE;
         else
            next_sleep_cnt = sleep_cnt + 2'h1;
      end
      else if (proc_start)
      begin
         if (selected)
         begin
            next_state = sws_pkg::SWS_READ;
            next_drive_q = state == sws_pkg::SWS_READ; // First cycle from deselect stays masked
         end
         else
            next_state = sws_pkg::SWS_IDLE;
      end
      else if (ctrl_start)
      begin
         if (!selected)
            next_state = sws_pkg::SWS_IDLE;
         else if (is_write)
         begin
            next_state = sws_pkg::SWS_WRITE;
            next_lane_write = lanes;
            next_write_strobe = 1'b1;
         end
         else
         begin
            next_state = sws_pkg::SWS_READ;
            next_drive_q = state == sws_pkg::SWS_READ;
         end
      end
      else if (cont)
      begin
         if (is_write)
         begin
            next_state = sws_pkg::SWS_WRITE;
            next_lane_write = lanes;
            next_write_strobe = 1'b1;
         end
         else if (state == sws_pkg::SWS_READ)
            next_drive_q = 1'b1;
         // After a write, reads resume only with a new strobe
         else
            next_state = sws_pkg::SWS_WRITE;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         state <= sws_pkg::SWS_IDLE;
         sleep_cnt <= sws_pkg::SLEEP_CNT_RST;
         lane_write <= sws_pkg::LANES_NONE;
         write_strobe <= 1'b0;
         drive_q <= 1'b0;
      end
      else
      begin
         state <= next_state;
         sleep_cnt <= next_sleep_cnt;
         lane_write <= next_lane_write;
         write_strobe <= next_write_strobe;
         drive_q <= next_drive_q;
      end
   end

   // Enable is a registered cycle qualifier gated by the live pin
   always_comb
   begin
      data_oe = (drive_q && !output_enable_n && !write_strobe) ? sws_pkg::LANES_ALL : sws_pkg::LANES_NONE;
      read_active = state == sws_pkg::SWS_READ;
      sleeping = state == sws_pkg::SWS_SLEEP;
   end

   property p_write_lanes;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state != sws_pkg::SWS_SLEEP && ctrl_start && selected && !global_write_n)
      |=> (lane_write == sws_pkg::LANES_ALL && write_strobe);
   endproperty
   a_write_lanes: assert property (p_write_lanes) else $error("global write not full");

   property p_byte_lanes;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state != sws_pkg::SWS_SLEEP && ctrl_start && selected && global_write_n
       && !byte_write_enable_n) |=> (lane_write == ~$past(byte_lane_select_n));
   endproperty
   a_byte_lanes: assert property (p_byte_lanes) else $error("byte lanes wrong");

   property p_proc_read;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state != sws_pkg::SWS_SLEEP && proc_start) |=> !write_strobe;
   endproperty
   a_proc_read: assert property (p_proc_read) else $error("write on processor strobe");

   property p_no_drive_write;
      @(posedge mclk) disable iff (!rst_n)
      write_strobe |-> data_oe == sws_pkg::LANES_NONE;
   endproperty
   a_no_drive_write: assert property (p_no_drive_write) else $error("driving during write");

   property p_oe_high;
      @(posedge mclk) disable iff (!rst_n)
      output_enable_n |-> data_oe == sws_pkg::LANES_NONE;
   endproperty
   a_oe_high: assert property (p_oe_high) else $error("driving with oe high");

   property p_sleep_exit;
      @(posedge mclk) disable iff (!rst_n)
      (sleeping && !sleep_request) |=> data_oe == sws_pkg::LANES_NONE;
   endproperty
   a_sleep_exit: assert property (p_sleep_exit) else $error("driving after sleep");

   property p_ignore_proc;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state == sws_pkg::SWS_IDLE && chip_sel_first_n && ctrl_addr_strobe_n) |=> !read_active;
   endproperty
   a_ignore_proc: assert property (p_ignore_proc) else $error("strobe taken while deselected");

   property p_after_write;
      @(posedge mclk) disable iff (!rst_n)
      (state == sws_pkg::SWS_WRITE && !sleep_request && proc_addr_strobe_n && ctrl_addr_strobe_n)
      |=> (data_oe == sws_pkg::LANES_NONE) [*2];
   endproperty
   a_after_write: assert property (p_after_write) else $error("driving after write");

   property p_single_write;
      @(posedge mclk) disable iff (!rst_n)
      write_strobe && $past(ctrl_start) |-> lane_write != sws_pkg::LANES_NONE;
   endproperty
   a_single_write: assert property (p_single_write) else $error("empty write strobe");

   property p_read_decode;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state != sws_pkg::SWS_SLEEP && ctrl_start && selected && global_write_n
       && (byte_write_enable_n || byte_lane_select_n == sws_pkg::LANES_ALL)) |=> (read_active && !write_strobe);
   endproperty
   a_read_decode: assert property (p_read_decode) else $error("read decoded as write");

   property p_continue_read;
      @(posedge mclk) disable iff (!rst_n)
      (!sleep_request && state == sws_pkg::SWS_READ && chip_sel_first_n && ctrl_addr_strobe_n && !is_write)
      |=> (read_active && drive_q);
   endproperty
   a_continue_read: assert property (p_continue_read) else $error("burst dropped on ignored strobe");
endmodule

// *** common/sws_pkg.sv ***
package sws_pkg;
   localparam int LANES = 4;
   localparam int LANE_BITS = 9;
   localparam int SLEEP_CYCLES = 2;
   localparam logic [3:0] LANES_NONE = 4'h0;
   localparam logic [3:0] LANES_ALL = 4'hf;
   localparam logic [1:0] SLEEP_CNT_RST = 2'h0;

   typedef enum logic [3:0] {
      SWS_IDLE = 4'h1,
      SWS_READ = 4'h2,
      SWS_WRITE = 4'h4,
      SWS_SLEEP = 4'h8
   } sws_state_e;

   // Active-high lane write mask; global write overrides byte controls
   function automatic logic [3:0] write_lanes(input logic gw_n, input logic bwe_n, input logic [3:0] bw_n);
      if (!gw_n)
         return LANES_ALL;
      else if (!bwe_n)
         return ~bw_n;
      else
         return LANES_NONE;
   endfunction
endpackage

// *** logic/sws_lane_decode.sv ***
`timescale 1ns/100ps
module sws_lane_decode
(
   input wire logic global_write_n,
   input wire logic byte_write_enable_n,
   input wire logic [3:0] byte_lane_select_n,
   output logic [3:0] lanes,
   output logic is_write
);
   always_comb
   begin
      lanes = sws_pkg::write_lanes(global_write_n, byte_write_enable_n, byte_lane_select_n);
      is_write = |lanes;
   end
endmodule

// *** verif/sws_master.sv ***
`timescale 1ns/100ps
module sws_master
(
   input wire logic mclk,
   output logic proc_addr_strobe_n,
   output logic ctrl_addr_strobe_n,
   output logic burst_advance_n,
   output logic chip_sel_first_n,
   output logic chip_sel_second,
   output logic chip_sel_third_n,
   output logic global_write_n,
   output logic byte_write_enable_n,
   output logic [3:0] byte_lane_select_n,
   output logic sleep_request,
   output logic output_enable_n
);
   // Control word is {proc, ctrl, global, byte enable}; os is {oe_n, selected}
   task automatic put(input logic [3:0] ctl, input logic [3:0] s, input logic [1:0] os);
      {proc_addr_strobe_n, ctrl_addr_strobe_n, global_write_n, byte_write_enable_n} = ctl;
      byte_lane_select_n = s;
      chip_sel_first_n = !os[0];
      chip_sel_second = os[0];
      chip_sel_third_n = !os[0];
      // Advance wobbles to show it never matters on a strobe edge
      burst_advance_n = s[0];
      // Outputs float before write data is offered on a controller strobe; continuation writes leave oe_n to os
      output_enable_n = os[1] | (!ctl[2] & ctl[3] & (!ctl[1] | (!ctl[0] & (s != 4'hf))));
      sleep_request = 1'h0;
   endtask

   task automatic cyc(input logic [3:0] ctl, input logic [3:0] s, input logic [1:0] os);
      @(negedge mclk);
      put(ctl, s, os);
   endtask

   // Deselect first, raise sleep one cycle later
   task automatic nap();
      cyc(4'hf, 4'hf, 2'h2);
      @(negedge mclk);
      sleep_request = 1'h1;
   endtask

   initial put(4'hf, 4'hf, 2'h2);
endmodule

// *** verif/sws_ctrl_test.sv ***
`timescale 1ns/100ps
module sws_ctrl_test;
   // Power-up wait shortened to keep the run brief
   localparam int POWER_WAIT = 4;
   logic mclk = 1'h0;
   logic rst_n = 1'h0;
   logic proc_addr_strobe_n, ctrl_addr_strobe_n, burst_advance_n, chip_sel_first_n, chip_sel_second;
   logic chip_sel_third_n, global_write_n, byte_write_enable_n, sleep_request, output_enable_n;
   logic [3:0] byte_lane_select_n;
   logic [3:0] lane_write;
   logic [3:0] data_oe;
   logic write_strobe, read_active, sleeping;
   int failures = 0;
   int samples_checked = 0;
   int cycles = 0;

   sws_ctrl uut
   (
      .mclk(mclk),
      .rst_n(rst_n),
      .proc_addr_strobe_n(proc_addr_strobe_n),
      .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
      .burst_advance_n(burst_advance_n),
      .chip_sel_first_n(chip_sel_first_n),
      .chip_sel_second(chip_sel_second),
      .chip_sel_third_n(chip_sel_third_n),
      .global_write_n(global_write_n),
      .byte_write_enable_n(byte_write_enable_n),
      .byte_lane_select_n(byte_lane_select_n),
      .sleep_request(sleep_request),
      .output_enable_n(output_enable_n),
      .lane_write(lane_write),
      .write_strobe(write_strobe),
      .data_oe(data_oe),
      .read_active(read_active),
      .sleeping(sleeping)
   );

   sws_master m
   (
      .mclk(mclk),
      .proc_addr_strobe_n(proc_addr_strobe_n),
      .ctrl_addr_strobe_n(ctrl_addr_strobe_n),
      .burst_advance_n(burst_advance_n),
      .chip_sel_first_n(chip_sel_first_n),
      .chip_sel_second(chip_sel_second),
      .chip_sel_third_n(chip_sel_third_n),
      .global_write_n(global_write_n),
      .byte_write_enable_n(byte_write_enable_n),
      .byte_lane_select_n(byte_lane_select_n),
      .sleep_request(sleep_request),
      .output_enable_n(output_enable_n)
   );

   always #5 mclk = ~mclk;

   task automatic complete_run();
      $display("checks=%0d failures=%0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask

   always @(posedge mclk)
   begin
      cycles++;
      if (cycles >= 2000)
      begin
         failures++;
         complete_run();
      end
   end

   task automatic chk(input logic [3:0] seen, input logic [3:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // Outputs settle just after the sampling edge
   task automatic step(input logic [3:0] ctl, input logic [3:0] s, input logic [1:0] os);
      m.cyc(ctl, s, os);
      @(posedge mclk);
      #1;
   endtask

   initial
   begin
      repeat (6) @(posedge mclk);
      #1;
      chk({write_strobe, read_active, sleeping, data_oe[0]}, 4'h0);
      @(negedge mclk);
      rst_n = 1'h1;
      repeat (POWER_WAIT) @(negedge mclk);
      step(4'h7, 4'hf, 2'h0);
      chk(read_active, 4'h0);
      for (int i = 0; i < 16; i++)
      begin
         step(4'ha, i[3:0], 2'h1);
         chk(lane_write, ~i[3:0]);
         chk(write_strobe, i != 15);
         chk(data_oe, 4'h0);
      end
      step(4'hb, 4'h0, 2'h1);
      chk(write_strobe, 4'h0);
      step(4'hf, 4'hf, 2'h1);
      chk(data_oe, 4'hf);
      step(4'h7, 4'hf, 2'h0);
      chk({read_active, data_oe[2:0]}, 4'hf);
      @(negedge mclk);
      m.output_enable_n = 1'h1;
      #1;
      chk(data_oe, 4'h0);
      step(4'h9, 4'hf, 2'h1);
      chk(lane_write, 4'hf);
      repeat (2)
      begin
         step(4'hf, 4'hf, 2'h1);
         chk(write_strobe, 4'h0);
         chk(data_oe, 4'h0);
      end
      step(4'h5, 4'hf, 2'h1);
      chk(write_strobe, 4'h0);
      step(4'hd, 4'hf, 2'h3);
      chk({write_strobe, lane_write[3:1]}, 4'hf);
      m.nap();
      @(posedge mclk);
      #1;
      chk(sleeping, 4'h1);
      step(4'hf, 4'hf, 2'h0);
      chk({sleeping, data_oe[2:0]}, 4'h8);
      @(posedge mclk);
      #1;
      chk({sleeping, data_oe[2:0]}, 4'h0);
      chk(data_oe, 4'h0);
      complete_run();
   end
endmodule
